// ### hw/uart_flow_map.svh
`ifndef UART_FLOW_MAP_SVH
`define UART_FLOW_MAP_SVH

// register placement and access key
`define FEATURE_ADDR 4'h2
`define LINE_CTRL_KEY 8'hBF
`define SPECIAL_FN_LOCK_BIT 2
`define FEATURE_RESET 8'h00

// enhanced feature field positions
`define FEAT_AUTO_CTS 7
`define FEAT_AUTO_RTS 6
`define FEAT_SPECIAL 5
`define FEAT_ENHANCED 4
`define FEAT_TX_HI 3
`define FEAT_TX_LO 2
`define FEAT_RX_HI 1
`define FEAT_RX_LO 0

// flow control select codes
`define FC_NONE 2'h0
`define FC_SET_TWO 2'h1
`define FC_SET_ONE 2'h2
`define FC_BOTH 2'h3

// interrupt identification codes
`define IDENT_FC_CODE 6'h10
`define IDENT_NONE_CODE 6'h01

`endif

// ### hw/uart_flow_pkg.sv
package uart_flow_pkg;

	typedef enum logic [2:0] {
		TX_IDLE = 3'b001,
		TX_FIRST = 3'b010,
		TX_SECOND = 3'b100
	} tx_state_e;

	typedef struct packed {
		logic [7:0] feat;
		logic [7:0] rdata;
		tx_state_e tx_st;
		logic [7:0] tx_char;
		logic tx_valid;
		logic tx_is_pause;
		logic want_pause;
		logic want_resume;
		logic fc_pend;
		logic sp_pend;
		logic peer_paused;
		logic cts_s1;
		logic cts_s2;
		logic rts_n;
	} top_s;

	typedef struct packed {
		logic pend_on;
		logic pend_off;
		logic push;
		logic [7:0] push_data;
		logic resume_hit;
		logic pause_hit;
		logic special_hit;
	} match_s;

endpackage

// ### hw/flow_match_if.sv
`timescale 1ns/1ps
`default_nettype none

interface flow_match_if;
	logic rx_valid;
	logic [7:0] rx_char;
	logic [1:0] rx_sel;
	logic [1:0] tx_sel;
	logic special_en;
	logic [7:0] resume_one;
	logic [7:0] resume_two;
	logic [7:0] pause_one;
	logic [7:0] pause_two;
	logic push;
	logic [7:0] push_data;
	logic resume_hit;
	logic pause_hit;
	logic special_hit;

	modport ctrl (
		output rx_valid, rx_char, rx_sel, tx_sel, special_en,
		output resume_one, resume_two, pause_one, pause_two,
		input push, push_data, resume_hit, pause_hit, special_hit
	);
	modport match (
		input rx_valid, rx_char, rx_sel, tx_sel, special_en,
		input resume_one, resume_two, pause_one, pause_two,
		output push, push_data, resume_hit, pause_hit, special_hit
	);
endinterface

`default_nettype wire

// ### hw/flow_char_match.sv
`timescale 1ns/1ps
`default_nettype none
`include "uart_flow_map.svh"

module flow_char_match
	import uart_flow_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// character stream and results
	flow_match_if.match m
);

	match_s st_reg;
	match_s st_next;
	logic sel_one;
	logic sel_two;
	logic either;
	logic dbl;
	logic on_hit;
	logic off_hit;
	logic consumed;

	// decode receive compare mode; mixed codes depend on the transmit pair
	always_comb
	begin
		sel_one = (m.rx_sel == `FC_SET_ONE);
		sel_two = (m.rx_sel == `FC_SET_TWO);
		either = (m.rx_sel == `FC_BOTH) && (m.tx_sel == `FC_SET_ONE || m.tx_sel == `FC_SET_TWO);
		dbl = (m.rx_sel == `FC_BOTH) && (m.tx_sel == `FC_BOTH || m.tx_sel == `FC_NONE);
	end

	// one character per valid; matched flow characters are swallowed, others, even the first of a double pair, go on to the fifo
	always_comb
	begin
		st_next = st_reg;
		st_next.push = 1'b0;
		st_next.resume_hit = 1'b0;
		st_next.pause_hit = 1'b0;
		st_next.special_hit = 1'b0;
		on_hit = 1'b0;
		off_hit = 1'b0;
		consumed = 1'b0;
		if (m.rx_valid)
		begin
			if (dbl)
			begin
				// double sequence: first char arms, second completes; first is still stored
				on_hit = st_reg.pend_on && (m.rx_char == m.resume_two);
				off_hit = st_reg.pend_off && (m.rx_char == m.pause_two);
				st_next.pend_on = (m.rx_char == m.resume_one);
				st_next.pend_off = (m.rx_char == m.pause_one);
			end
			else
			begin
				on_hit = ((sel_one || either) && m.rx_char == m.resume_one) ||
					((sel_two || either) && m.rx_char == m.resume_two);
				off_hit = ((sel_one || either) && m.rx_char == m.pause_one) ||
					((sel_two || either) && m.rx_char == m.pause_two);
				st_next.pend_on = 1'b0;
				st_next.pend_off = 1'b0;
			end
			consumed = on_hit || off_hit;
			st_next.resume_hit = on_hit;
			st_next.pause_hit = off_hit;
			st_next.special_hit = m.special_en && (m.rx_char == m.pause_two);
			st_next.push = !consumed;
			st_next.push_data = m.rx_char;
		end
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign m.push = st_reg.push;
	assign m.push_data = st_reg.push_data;
	assign m.resume_hit = st_reg.resume_hit;
	assign m.pause_hit = st_reg.pause_hit;
	assign m.special_hit = st_reg.special_hit;

	property p_special_store;
		@(posedge sys_clk) disable iff (rst)
		(m.rx_valid && m.special_en && m.rx_char == m.pause_two && m.rx_sel == `FC_NONE)
		|=> (m.push && m.special_hit && m.push_data == $past(m.rx_char));
	endproperty
	a_special_store: assert property (p_special_store) else $error("special char not stored and flagged");

	property p_special_fc;
		@(posedge sys_clk) disable iff (rst)
		(m.rx_valid && m.special_en && m.rx_char == m.pause_two && m.rx_sel == `FC_SET_TWO)
		|=> (!m.push && m.pause_hit && m.special_hit);
	endproperty
	a_special_fc: assert property (p_special_fc) else $error("pause_two under flow control mishandled");

	property p_single_one;
		@(posedge sys_clk) disable iff (rst)
		(m.rx_valid && m.rx_sel == `FC_SET_ONE && m.rx_char == m.resume_one) |=> (m.resume_hit && !m.push);
	endproperty
	a_single_one: assert property (p_single_one) else $error("first resume char not matched");

	property p_none_passes;
		@(posedge sys_clk) disable iff (rst)
		(m.rx_valid && m.rx_sel == `FC_NONE) |=> (m.push && !m.pause_hit && !m.resume_hit);
	endproperty
	a_none_passes: assert property (p_none_passes) else $error("char swallowed with no rx flow control");

	property p_double_pause;
		@(posedge sys_clk) disable iff (rst)
		(m.rx_valid && dbl && m.rx_char == m.pause_one && m.pause_one != m.pause_two)
		##1 (!m.rx_valid && dbl) [*2]
		##1 (m.rx_valid && dbl && m.rx_char == m.pause_two) |=> m.pause_hit;
	endproperty
	a_double_pause: assert property (p_double_pause) else $error("double pause sequence not detected");

	property p_double_single;
		@(posedge sys_clk) disable iff (rst)
		(m.rx_valid && dbl && m.rx_char != m.pause_two) |=> !m.pause_hit;
	endproperty
	a_double_single: assert property (p_double_single) else $error("pause acted on a lone char in double mode");

	c_double: cover property (@(posedge sys_clk) disable iff (rst) m.pause_hit && dbl);
	c_special: cover property (@(posedge sys_clk) disable iff (rst) m.special_hit && m.push);

endmodule

`default_nettype wire

// ### hw/uart_flow_control_config.sv
// Behaviour
// - the enhanced feature register is read and written only while line control holds 0xBF and special function bit 2 is low, and resets to zero.
// - bit 7 turns automatic CTS flow control on or off.
// - bit 6 turns automatic RTS flow control on or off.
// - with bit 5 set, a received second pause char is stored in the receive fifo and flagged as a special char in ident bit 4.
// - if that char also completes a flow control pause match, it acts as pause, is not stored, and raises both pause and special interrupts.
// - bit 4 unlocks writes to the extended interrupt enable, ident, fifo control, modem control, transmission control and trigger level bits, and enables sleep.
// - bits 3:2 pick transmit flow chars: none, the first pair, the second pair, or both pairs in sequence.
// - bits 1:0 pick receive compare: none, the first pair, or the second pair.
// - codes 1011 and 0111 send the first or second pair and the receiver accepts either resume and either pause char.
// - code 1111 sends double chars and the receiver needs first and second together before acting.
// - code 0011 sends nothing and the receiver compares the double sequences.
// - a received pause or special char is reported with ident code 010000.
`timescale 1ns/1ps
`default_nettype none
`include "uart_flow_map.svh"

module uart_flow_control_config
	import uart_flow_pkg::*;
#(
	parameter int LEVEL_W = 7
)
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// register port from the host interface
	input wire logic [3:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic [7:0] line_control_reg,
	input wire logic [7:0] special_function_reg,
	// feature controls to the uart core
	output logic auto_cts_en,
	output logic auto_rts_en,
	output logic enhanced_write_en,
	output logic sleep_allow,
	// interrupt identification
	input wire logic ident_read,
	output logic [5:0] ident_code,
	output logic special_flag,
	// receive path
	input wire logic rx_valid,
	input wire logic [7:0] rx_char,
	input wire logic [7:0] resume_char_one,
	input wire logic [7:0] resume_char_two,
	input wire logic [7:0] pause_char_one,
	input wire logic [7:0] pause_char_two,
	output logic rx_fifo_push,
	output logic [7:0] rx_fifo_data,
	output logic peer_paused,
	// transmit flow characters
	input wire logic send_pause,
	input wire logic send_resume,
	output logic tx_fc_valid,
	output logic [7:0] tx_fc_char,
	input wire logic tx_fc_ready,
	// modem pins and fifo levels
	input wire logic cts_n,
	output logic rts_n,
	output logic tx_hold,
	input wire logic modem_rts,
	input wire logic [LEVEL_W-1:0] rx_level,
	input wire logic [LEVEL_W-1:0] halt_level,
	input wire logic [LEVEL_W-1:0] resume_level
);

	// elaboration guard: narrower levels cannot count a full 64-entry fifo
	if (LEVEL_W < 7 || LEVEL_W > 16)
	begin : g_level_check
		$error("LEVEL_W must hold a 64-entry fifo level");
	end

	top_s st_reg;
	top_s st_next;
	logic feat_open;
	logic feat_hit;
	logic [1:0] tx_sel;

	flow_match_if mif ();

	assign mif.rx_valid = rx_valid;
	assign mif.rx_char = rx_char;
	assign mif.rx_sel = st_reg.feat[`FEAT_RX_HI:`FEAT_RX_LO];
	assign mif.tx_sel = tx_sel;
	assign mif.special_en = st_reg.feat[`FEAT_SPECIAL];
	assign mif.resume_one = resume_char_one;
	assign mif.resume_two = resume_char_two;
	assign mif.pause_one = pause_char_one;
	assign mif.pause_two = pause_char_two;

	flow_char_match u_match (
		.sys_clk(sys_clk),
		.rst(rst),
		.m(mif.match)
	);

	// access key: the register shares its offset, so only the key opens it
	assign feat_open = (line_control_reg == `LINE_CTRL_KEY) && !special_function_reg[`SPECIAL_FN_LOCK_BIT];
	assign feat_hit = feat_open && (reg_addr == `FEATURE_ADDR);
	assign tx_sel = st_reg.feat[`FEAT_TX_HI:`FEAT_TX_LO];

	always_comb
	begin
		st_next = st_reg;
		// register port
		if (reg_wr && feat_hit)
			st_next.feat = reg_wdata;
		if (reg_rd)
			st_next.rdata = feat_hit ? st_reg.feat : 8'h00;
		// sticky ident sources; a new event in the clearing cycle survives
		if (ident_read)
		begin
			st_next.fc_pend = 1'b0;
			st_next.sp_pend = 1'b0;
		end
		if (mif.pause_hit)
			st_next.fc_pend = 1'b1;
		if (mif.special_hit)
			st_next.sp_pend = 1'b1;
		// remote flow state follows the last matched char
		if (mif.pause_hit)
			st_next.peer_paused = 1'b1;
		else if (mif.resume_hit)
			st_next.peer_paused = 1'b0;
		// requests wait until the sequencer is free
		if (send_pause)
			st_next.want_pause = 1'b1;
		if (send_resume)
			st_next.want_resume = 1'b1;
		unique case (st_reg.tx_st)
			TX_IDLE:
			begin
				if (tx_sel == `FC_NONE)
				begin
					st_next.want_pause = 1'b0;
					st_next.want_resume = 1'b0;
				end
				else if (st_reg.want_pause || st_reg.want_resume)
				begin
					// pause outranks resume, since it protects the receive fifo
					st_next.tx_is_pause = st_reg.want_pause;
					if (st_reg.want_pause)
						st_next.want_pause = 1'b0;
					else
						st_next.want_resume = 1'b0;
					if (tx_sel == `FC_SET_TWO)
						st_next.tx_char = st_reg.want_pause ? pause_char_two : resume_char_two;
					else
						st_next.tx_char = st_reg.want_pause ? pause_char_one : resume_char_one;
					st_next.tx_valid = 1'b1;
					st_next.tx_st = TX_FIRST;
				end
			end
			TX_FIRST:
			begin
				if (tx_fc_ready)
				begin
					if (tx_sel == `FC_BOTH)
					begin
						st_next.tx_char = st_reg.tx_is_pause ? pause_char_two : resume_char_two;
						st_next.tx_st = TX_SECOND;
					end
					else
					begin
						st_next.tx_valid = 1'b0;
						st_next.tx_st = TX_IDLE;
					end
				end
			end
			TX_SECOND:
			begin
				if (tx_fc_ready)
				begin
					st_next.tx_valid = 1'b0;
					st_next.tx_st = TX_IDLE;
				end
			end
			default:
			begin
				st_next.tx_valid = 1'b0;
				st_next.tx_st = TX_IDLE;
			end
		endcase
		// cts pin synchroniser
		st_next.cts_s1 = cts_n;
		st_next.cts_s2 = st_reg.cts_s1;
		// rts with hysteresis between halt and resume levels
		if (!st_reg.feat[`FEAT_AUTO_RTS])
			st_next.rts_n = !modem_rts;
		else if (rx_level >= halt_level)
			st_next.rts_n = 1'b1;
		else if (rx_level <= resume_level)
			st_next.rts_n = 1'b0;
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			st_reg <= '0;
			st_reg.feat <= `FEATURE_RESET;
			st_reg.tx_st <= TX_IDLE;
			st_reg.rts_n <= 1'b1;
			st_reg.cts_s1 <= 1'b1;
			st_reg.cts_s2 <= 1'b1;
		end
		else
			st_reg <= st_next;
	end

	// outputs
	assign reg_rdata = st_reg.rdata;
	assign auto_cts_en = st_reg.feat[`FEAT_AUTO_CTS];
	assign auto_rts_en = st_reg.feat[`FEAT_AUTO_RTS];
	assign enhanced_write_en = st_reg.feat[`FEAT_ENHANCED];
	assign sleep_allow = st_reg.feat[`FEAT_ENHANCED];
	assign ident_code = (st_reg.fc_pend || st_reg.sp_pend) ? `IDENT_FC_CODE : `IDENT_NONE_CODE;
	assign special_flag = st_reg.sp_pend;
	assign rx_fifo_push = mif.push;
	assign rx_fifo_data = mif.push_data;
	assign peer_paused = st_reg.peer_paused;
	assign tx_fc_valid = st_reg.tx_valid;
	assign tx_fc_char = st_reg.tx_char;
	assign rts_n = st_reg.rts_n;
	// the core finishes the character in flight before it honours the hold
	assign tx_hold = st_reg.feat[`FEAT_AUTO_CTS] && st_reg.cts_s2;

	property p_locked;
		@(posedge sys_clk) disable iff (rst)
		(reg_wr && reg_addr == `FEATURE_ADDR && !feat_open) |=> $stable(st_reg.feat);
	endproperty
	a_locked: assert property (p_locked) else $error("locked register changed");

	property p_write;
		@(posedge sys_clk) disable iff (rst)
		(reg_wr && feat_hit) |=> (enhanced_write_en == $past(reg_wdata[`FEAT_ENHANCED]) &&
			auto_cts_en == $past(reg_wdata[`FEAT_AUTO_CTS]));
	endproperty
	a_write: assert property (p_write) else $error("enhanced bits not taken");

	property p_cts;
		@(posedge sys_clk) disable iff (rst)
		(auto_cts_en && cts_n) [*3] |-> tx_hold;
	endproperty
	a_cts: assert property (p_cts) else $error("inactive cts did not hold transmitter");

	property p_rts;
		@(posedge sys_clk) disable iff (rst)
		(auto_rts_en && rx_level >= halt_level) |=> rts_n;
	endproperty
	a_rts: assert property (p_rts) else $error("rts not dropped at halt level");

	property p_tx_none;
		@(posedge sys_clk) disable iff (rst)
		(tx_sel == `FC_NONE && st_reg.tx_st == TX_IDLE) |=> !tx_fc_valid;
	endproperty
	a_tx_none: assert property (p_tx_none) else $error("flow char sent with no tx flow control");

	property p_tx_both;
		@(posedge sys_clk) disable iff (rst)
		(st_reg.tx_st == TX_FIRST && tx_fc_ready && tx_sel == `FC_BOTH && st_reg.tx_is_pause)
		|=> (tx_fc_valid && tx_fc_char == pause_char_two);
	endproperty
	a_tx_both: assert property (p_tx_both) else $error("second pause char not sent");

	property p_iir;
		@(posedge sys_clk) disable iff (rst)
		mif.pause_hit |=> (ident_code == `IDENT_FC_CODE);
	endproperty
	a_iir: assert property (p_iir) else $error("pause not reported in ident code");

	property p_set_wins;
		@(posedge sys_clk) disable iff (rst)
		(mif.special_hit && ident_read) |=> special_flag;
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("special flag lost on clear");

	c_tx_both: cover property (@(posedge sys_clk) disable iff (rst) st_reg.tx_st == TX_SECOND && tx_fc_ready);
	c_hold: cover property (@(posedge sys_clk) disable iff (rst) tx_hold);
	c_rts: cover property (@(posedge sys_clk) disable iff (rst) auto_rts_en && $rose(rts_n));

endmodule

`default_nettype wire

// ### bench/uart_peer_model.sv
`timescale 1ns/1ps
`default_nettype none

module uart_peer_model
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// behaviour chosen by the bench
	input wire logic cts_block,
	input wire logic [3:0] accept_delay,
	// flow characters offered by the device
	input wire logic tx_fc_valid,
	input wire logic [7:0] tx_fc_char,
	output logic tx_fc_ready,
	// modem pin driven by the peer
	output logic cts_n,
	// the last two characters taken and their count
	output logic [7:0] got_char,
	output logic [7:0] got_prev,
	output logic [7:0] got_count
);
	logic [3:0] wait_cnt;

	// pins move on the falling edge; a slow peer holds ready low for accept_delay cycles per char, one more when the char follows a taken one
	always @(negedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			tx_fc_ready <= 1'b0;
			wait_cnt <= 4'h0;
			cts_n <= 1'b0;
		end
		else
		begin
			cts_n <= cts_block;
			if (!tx_fc_valid || tx_fc_ready)
			begin
				// ready falls after each taken char unless the peer is prompt and another char is still offered
				tx_fc_ready <= tx_fc_valid && accept_delay == 4'h0;
				wait_cnt <= 4'h0;
			end
			else if (wait_cnt >= accept_delay)
				tx_fc_ready <= 1'b1;
			else
				wait_cnt <= wait_cnt + 4'h1;
		end
	end

	// a char counts as sent only at an edge with valid and ready both high
	always @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			got_char <= 8'h00;
			got_prev <= 8'h00;
			got_count <= 8'h00;
		end
		else if (tx_fc_valid && tx_fc_ready)
		begin
			got_prev <= got_char;
			got_char <= tx_fc_char;
			got_count <= got_count + 8'h01;
		end
	end
endmodule

`default_nettype wire

// ### bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "uart_flow_map.svh"

module tb;
	localparam logic [7:0] res_one = 8'h11;
	localparam logic [7:0] res_two = 8'h12;
	localparam logic [7:0] pau_one = 8'h13;
	localparam logic [7:0] pau_two = 8'h14;
	logic sys_clk, rst, reg_wr, reg_rd, ident_read, rx_valid, send_pause, send_resume, modem_rts, cts_block;
	logic [3:0] reg_addr, accept_delay;
	logic [7:0] reg_wdata, line_ctrl, special_fn, rx_char, reg_rdata, tx_fc_char, rx_fifo_data;
	logic [7:0] got_char, got_prev, got_count;
	logic [6:0] rx_level, halt_level, resume_level;
	logic [5:0] ident_code;
	logic auto_cts_en, auto_rts_en, enhanced_write_en, sleep_allow, special_flag, rx_fifo_push, peer_paused;
	logic tx_fc_valid, tx_fc_ready, cts_n, rts_n, tx_hold;
	int miscompares, n_compared;

	// device under test
	uart_flow_control_config #(.LEVEL_W(7)) dut
	(
		.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .line_control_reg(line_ctrl),
		.special_function_reg(special_fn),
		.auto_cts_en(auto_cts_en), .auto_rts_en(auto_rts_en), .enhanced_write_en(enhanced_write_en),
		.sleep_allow(sleep_allow), .ident_read(ident_read), .ident_code(ident_code), .special_flag(special_flag),
		.rx_valid(rx_valid), .rx_char(rx_char), .resume_char_one(res_one), .resume_char_two(res_two),
		.pause_char_one(pau_one), .pause_char_two(pau_two), .rx_fifo_push(rx_fifo_push),
		.rx_fifo_data(rx_fifo_data), .peer_paused(peer_paused), .send_pause(send_pause),
		.send_resume(send_resume), .tx_fc_valid(tx_fc_valid), .tx_fc_char(tx_fc_char),
		.tx_fc_ready(tx_fc_ready), .cts_n(cts_n), .rts_n(rts_n), .tx_hold(tx_hold), .modem_rts(modem_rts),
		.rx_level(rx_level), .halt_level(halt_level), .resume_level(resume_level)
	);

	// remote peer on the flow control side
	uart_peer_model peer
	(
		.sys_clk(sys_clk), .rst(rst), .cts_block(cts_block), .accept_delay(accept_delay),
		.tx_fc_valid(tx_fc_valid), .tx_fc_char(tx_fc_char), .tx_fc_ready(tx_fc_ready), .cts_n(cts_n),
		.got_char(got_char), .got_prev(got_prev), .got_count(got_count)
	);

	// clock at 100 MHz
	initial
	begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic test_done();
		$display("comparisons %0d miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// register access: one-cycle strobes, read data taken a cycle later
	task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
		@(negedge sys_clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge sys_clk);
		reg_wr = 1'b0;
	endtask

	task automatic reg_read(input logic [3:0] a, output logic [7:0] d);
		@(negedge sys_clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge sys_clk);
		reg_rd = 1'b0;
		d = reg_rdata;
	endtask

	task automatic set_feat(input logic [7:0] d);
		line_ctrl = `LINE_CTRL_KEY;
		special_fn = 8'h00;
		reg_write(`FEATURE_ADDR, d);
	endtask

	task automatic clear_ident();
		@(negedge sys_clk);
		ident_read = 1'b1;
		@(negedge sys_clk);
		ident_read = 1'b0;
	endtask

	// one received char; push, data and pause state are judged once they have settled
	task automatic rxc(input logic [7:0] c, input logic push_exp, input logic paused_exp);
		@(negedge sys_clk);
		rx_valid = 1'b1;
		rx_char = c;
		@(negedge sys_clk);
		rx_valid = 1'b0;
		check("rx push", rx_fifo_push, push_exp);
		if (push_exp)
			check("rx data", rx_fifo_data, c);
		@(negedge sys_clk);
		check("peer paused", peer_paused, paused_exp);
	endtask

	task automatic t_reset_and_lock();
		logic [7:0] d;
		// read the reset value with the key open, so a nonzero reset would show
		line_ctrl = `LINE_CTRL_KEY;
		reg_read(`FEATURE_ADDR, d);
		check("feature reset", d, 8'h00);
		check("ident idle", ident_code, 6'h01);
		check("rts manual", rts_n, !modem_rts);
		line_ctrl = 8'h3F;
		reg_write(`FEATURE_ADDR, 8'hFF);
		special_fn = 8'h04;
		line_ctrl = `LINE_CTRL_KEY;
		reg_write(`FEATURE_ADDR, 8'hFF);
		reg_read(`FEATURE_ADDR, d);
		check("locked read", d, 8'h00);
		special_fn = 8'h00;
		reg_read(`FEATURE_ADDR, d);
		check("refused writes", d, 8'h00);
		check("auto cts off", auto_cts_en, 1'b0);
		reg_read(4'h3, d);
		check("other address", d, 8'h00);
	endtask

	task automatic t_enables();
		logic [7:0] d;
		set_feat(8'hC0);
		check("auto cts", auto_cts_en, 1'b1);
		check("auto rts", auto_rts_en, 1'b1);
		check("enh off", enhanced_write_en, 1'b0);
		check("sleep off", sleep_allow, 1'b0);
		reg_read(`FEATURE_ADDR, d);
		check("readback", d, 8'hC0);
		set_feat(8'h10);
		check("auto cts clr", auto_cts_en, 1'b0);
		check("auto rts clr", auto_rts_en, 1'b0);
		check("enh on", enhanced_write_en, 1'b1);
		check("sleep on", sleep_allow, 1'b1);
	endtask

	// one flow request; n chars must reach the peer, the last two being first and last
	task automatic tx_case(input logic [7:0] feat, input logic pause, input logic [7:0] n, input logic [7:0] first,
		input logic [7:0] last);
		logic [7:0] base;
		int i;
		set_feat(feat);
		base = got_count;
		@(negedge sys_clk);
		send_pause = pause;
		send_resume = !pause;
		@(negedge sys_clk);
		send_pause = 1'b0;
		send_resume = 1'b0;
		for (i = 0; i < 40 && got_count !== base + n; i++)
			@(negedge sys_clk);
		if (i == 40)
		begin
			miscompares++;
			test_done();
		end
		repeat (12) @(negedge sys_clk);
		check("fc count", got_count, base + n);
		check("fc idle", tx_fc_valid, 1'b0);
		if (n != 8'h00)
			check("fc last", got_char, last);
		if (n == 8'h02)
			check("fc first", got_prev, first);
	endtask

	task automatic t_receive();
		set_feat(8'h02);
		rxc(pau_two, 1'b1, 1'b0);
		rxc(pau_one, 1'b0, 1'b1);
		check("ident pause", ident_code, 6'h10);
		clear_ident();
		check("ident clear", ident_code, 6'h01);
		rxc(res_one, 1'b0, 1'b0);
		set_feat(8'h01);
		rxc(pau_one, 1'b1, 1'b0);
		rxc(pau_two, 1'b0, 1'b1);
		rxc(res_two, 1'b0, 1'b0);
		set_feat(8'h0B);
		rxc(pau_two, 1'b0, 1'b1);
		rxc(res_one, 1'b0, 1'b0);
		set_feat(8'h0F);
		rxc(pau_one, 1'b1, 1'b0);
		rxc(pau_two, 1'b0, 1'b1);
		rxc(res_one, 1'b1, 1'b1);
		rxc(8'h55, 1'b1, 1'b1);
		rxc(res_two, 1'b1, 1'b1);
		rxc(res_one, 1'b1, 1'b1);
		rxc(res_two, 1'b0, 1'b0);
		set_feat(8'h03);
		rxc(pau_one, 1'b1, 1'b0);
		rxc(pau_two, 1'b0, 1'b1);
		rxc(res_one, 1'b1, 1'b1);
		rxc(res_two, 1'b0, 1'b0);
		clear_ident();
		set_feat(8'h20);
		rxc(pau_two, 1'b1, 1'b0);
		check("special", special_flag, 1'b1);
		check("ident special", ident_code, 6'h10);
		clear_ident();
		check("special clr", special_flag, 1'b0);
		set_feat(8'h21);
		rxc(pau_two, 1'b0, 1'b1);
		check("special fc", special_flag, 1'b1);
		clear_ident();
		rxc(res_two, 1'b0, 1'b0);
	endtask

	task automatic t_modem();
		set_feat(8'h80);
		cts_block = 1'b1;
		repeat (5) @(negedge sys_clk);
		check("tx hold", tx_hold, 1'b1);
		cts_block = 1'b0;
		repeat (5) @(negedge sys_clk);
		check("tx free", tx_hold, 1'b0);
		set_feat(8'h00);
		cts_block = 1'b1;
		repeat (5) @(negedge sys_clk);
		check("hold off", tx_hold, 1'b0);
		cts_block = 1'b0;
		set_feat(8'h40);
		rx_level = 7'd32;
		repeat (2) @(negedge sys_clk);
		check("rts halt", rts_n, 1'b1);
		rx_level = 7'd20;
		repeat (2) @(negedge sys_clk);
		check("rts between", rts_n, 1'b1);
		rx_level = 7'd16;
		repeat (2) @(negedge sys_clk);
		check("rts resume", rts_n, 1'b0);
		set_feat(8'h00);
		rx_level = 7'd40;
		modem_rts = 1'b0;
		repeat (2) @(negedge sys_clk);
		check("rts manual", rts_n, 1'b1);
		modem_rts = 1'b1;
	endtask

	// bound on the whole run
	initial
	begin
		repeat (20000) @(posedge sys_clk);
		miscompares++;
		test_done();
	end

	// main sequence
	initial
	begin
		{rst, reg_wr, reg_rd, ident_read, rx_valid, send_pause, send_resume, cts_block} = 8'h80;
		{reg_addr, accept_delay, reg_wdata, rx_char} = 24'h0000_00;
		{line_ctrl, special_fn} = 16'h0000;
		modem_rts = 1'b1;
		{rx_level, halt_level, resume_level} = {7'd0, 7'd32, 7'd16};
		// six rising edges inside reset, released on a falling edge
		repeat (6) @(negedge sys_clk);
		rst = 1'b0;
		t_reset_and_lock();
		t_enables();
		tx_case(8'h0B, 1'b1, 8'h01, 8'h00, pau_one);
		tx_case(8'h07, 1'b1, 8'h01, 8'h00, pau_two);
		tx_case(8'h0C, 1'b1, 8'h02, pau_one, pau_two);
		tx_case(8'h03, 1'b1, 8'h00, 8'h00, 8'h00);
		accept_delay = 4'h3;
		tx_case(8'h0F, 1'b0, 8'h02, res_one, res_two);
		tx_case(8'h08, 1'b0, 8'h01, 8'h00, res_one);
		accept_delay = 4'h0;
		t_receive();
		t_modem();
		test_done();
	end
endmodule

`default_nettype wire
